/* core/lrx_map.svh */
// Constants for the literal/return/exclusive-OR execution block
`ifndef LRX_MAP_SVH
`define LRX_MAP_SVH

// Opcode masks and match values (14-bit instruction word)
`define LRX_MASK_LIT2 14'h3c00
`define LRX_MASK_LIT3 14'h3f00
`define LRX_MASK_FULL 14'h3fff
`define LRX_MASK_NOP 14'h3f9f
`define LRX_OP_LOADLIT 14'h3000
`define LRX_OP_LITRET 14'h3400
`define LRX_OP_XORLIT 14'h3a00
`define LRX_OP_XORFILE 14'h0600
`define LRX_OP_SUBRET 14'h0008
`define LRX_OP_IRQRET 14'h0009
`define LRX_OP_NOP 14'h0000

// Operand field positions
`define LRX_LIT_MSB 7
`define LRX_LIT_LSB 0
`define LRX_FADDR_MSB 6
`define LRX_FADDR_LSB 0
`define LRX_DEST_BIT 7

// Position of the global interrupt enable in the interrupt control register
`define LRX_IRQEN_BIT 7

// Reset values
`define LRX_W_RST 8'h00
`define LRX_PC_RST 13'h0000
`define LRX_IRQEN_RST 1'b0
`define LRX_Z_RST 1'b0
`define LRX_FADDR_RST 7'h00
`define LRX_WDATA_RST 8'h00

// Instruction cycles of a return operation
`define LRX_RET_CYCLES 2

`endif

/* core/lrx_pkg.sv */
// Types shared by the execution block and its decoder
`default_nettype none
package lrx_pkg;

   typedef logic [7:0] lrx_byte_t;
   typedef logic [12:0] lrx_pc_t;
   typedef logic [13:0] lrx_instr_t;
   typedef logic [6:0] lrx_faddr_t;

   // Operations this block executes
   typedef enum logic [2:0] {
      LRX_NOP,
      LRX_LOADLIT,
      LRX_LITRET,
      LRX_SUBRET,
      LRX_IRQRET,
      LRX_XORLIT,
      LRX_XORFILE,
      LRX_UNKNOWN
   } lrx_op_e;

   // Sequencer states
   typedef enum logic [1:0] {
      LRX_ST_IDLE,
      LRX_ST_RET2,
      LRX_ST_FREAD
   } lrx_state_e;

endpackage : lrx_pkg
`default_nettype wire

/* core/lrx_decode.sv */
// Instruction decoder for the literal/return/exclusive-OR execution block
`timescale 1ns/1ps
`default_nettype none
`include "lrx_map.svh"

module lrx_decode (
   // Instruction word
   input wire lrx_pkg::lrx_instr_t instr_i,
   // Decoded fields
   output lrx_pkg::lrx_op_e op_o,
   output lrx_pkg::lrx_byte_t literal_o,
   output lrx_pkg::lrx_faddr_t faddr_o,
   output logic dest_file_o
);
   import lrx_pkg::*;

   // Masked opcode compare, used for every pattern
   function automatic logic op_match(input lrx_instr_t word, input lrx_instr_t mask,
                                     input lrx_instr_t value);
      op_match = ((word & mask) == value);
   endfunction : op_match

   // Classify the word; unlisted opcodes fall to unknown
   always_comb begin
      if (op_match(instr_i, `LRX_MASK_LIT2, `LRX_OP_LOADLIT)) begin
         op_o = LRX_LOADLIT;
      end else if (op_match(instr_i, `LRX_MASK_LIT2, `LRX_OP_LITRET)) begin
         op_o = LRX_LITRET;
      end else if (op_match(instr_i, `LRX_MASK_LIT3, `LRX_OP_XORLIT)) begin
         op_o = LRX_XORLIT;
      end else if (op_match(instr_i, `LRX_MASK_LIT3, `LRX_OP_XORFILE)) begin
         op_o = LRX_XORFILE;
      end else if (op_match(instr_i, `LRX_MASK_FULL, `LRX_OP_SUBRET)) begin
         op_o = LRX_SUBRET;
      end else if (op_match(instr_i, `LRX_MASK_FULL, `LRX_OP_IRQRET)) begin
         op_o = LRX_IRQRET;
      end else if (op_match(instr_i, `LRX_MASK_NOP, `LRX_OP_NOP)) begin
         op_o = LRX_NOP;
      end else begin
         op_o = LRX_UNKNOWN;
      end
   end

   // Operand fields sit at fixed positions for all formats
   assign literal_o = instr_i[`LRX_LIT_MSB:`LRX_LIT_LSB];
   assign faddr_o = instr_i[`LRX_FADDR_MSB:`LRX_FADDR_LSB];
   assign dest_file_o = instr_i[`LRX_DEST_BIT];

endmodule : lrx_decode
`default_nettype wire

/* core/lrx_exec.sv */
// Execution unit for literal load, no-op, returns and exclusive-OR operations
`timescale 1ns/1ps
`default_nettype none
`include "lrx_map.svh"

module lrx_exec (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Instruction issue
   input wire logic instr_valid_i,
   input wire lrx_pkg::lrx_instr_t instr_i,
   output logic instr_ready_o,
   output logic retire_o,
   output logic illegal_o,
   // Hardware stack
   input wire lrx_pkg::lrx_pc_t stack_top_i,
   output logic stack_pop_o,
   // File register port
   output lrx_pkg::lrx_faddr_t file_addr_o,
   input wire lrx_pkg::lrx_byte_t file_rdata_i,
   output logic file_we_o,
   output lrx_pkg::lrx_byte_t file_wdata_o,
   // Interrupt control
   input wire logic irq_en_clear_i,
   output logic global_irq_enable_o,
   // Core state
   output lrx_pkg::lrx_byte_t work_o,
   output logic zero_flag_o,
   output lrx_pkg::lrx_pc_t pc_o
);
   import lrx_pkg::*;

   // Decoded instruction
   lrx_op_e op;
   lrx_byte_t literal;
   lrx_faddr_t faddr;
   logic dest_file;

   // Sequencer and architectural state
   lrx_state_e state_r, state_nxt;
   lrx_byte_t work_r, work_nxt;
   logic zero_r, zero_nxt;
   logic irq_en_r, irq_en_nxt;
   lrx_pc_t pc_r, pc_nxt;
   logic dest_file_r, dest_file_nxt;
   lrx_faddr_t faddr_r, faddr_nxt;

   // Registered strobes and port values
   logic ready_r, ready_nxt;
   logic retire_r, retire_nxt;
   logic illegal_r, illegal_nxt;
   logic pop_r, pop_nxt;
   logic we_r, we_nxt;
   lrx_byte_t wdata_r, wdata_nxt;

   // Scratch result of the file exclusive-OR
   lrx_byte_t xor_res;

   // Program counter advance, wraps at the top of the space
   function automatic lrx_pc_t pc_inc(input lrx_pc_t pc);
      pc_inc = pc + 13'h0001;
   endfunction : pc_inc

   // Zero test shared by both exclusive-OR forms
   function automatic logic is_zero(input lrx_byte_t value);
      is_zero = (value == 8'h00);
   endfunction : is_zero

   // Opcode classification
   lrx_decode lrx_decode_i (
      .instr_i(instr_i),
      .op_o(op),
      .literal_o(literal),
      .faddr_o(faddr),
      .dest_file_o(dest_file)
   );

   // Next-state logic of the sequencer and the core state
   always_comb begin
      state_nxt = state_r;
      work_nxt = work_r;
      zero_nxt = zero_r;
      irq_en_nxt = irq_en_r;
      pc_nxt = pc_r;
      dest_file_nxt = dest_file_r;
      faddr_nxt = faddr_r;
      retire_nxt = 1'b0;
      illegal_nxt = 1'b0;
      pop_nxt = 1'b0;
      we_nxt = 1'b0;
      wdata_nxt = wdata_r;
      xor_res = work_r ^ file_rdata_i;
      // Interrupt entry clears the enable; an interrupt return in the same cycle overrides below
      if (irq_en_clear_i) begin
         irq_en_nxt = 1'b0;
      end
      case (state_r)
         LRX_ST_IDLE: begin
            // Words offered while ready is low are dropped, not held; this also
            // refuses the first cycle after reset, where ready is still low
            if (instr_valid_i && ready_r) begin
               case (op)
                  LRX_LOADLIT: begin
                     work_nxt = literal;
                     pc_nxt = pc_inc(pc_r);
                     retire_nxt = 1'b1;
                  end
                  LRX_NOP: begin
                     pc_nxt = pc_inc(pc_r);
                     retire_nxt = 1'b1;
                  end
                  LRX_XORLIT: begin
                     work_nxt = work_r ^ literal;
                     zero_nxt = is_zero(work_r ^ literal);
                     pc_nxt = pc_inc(pc_r);
                     retire_nxt = 1'b1;
                  end
                  LRX_XORFILE: begin
                     // File data is read on the next cycle, so hold address and destination
                     faddr_nxt = faddr;
                     dest_file_nxt = dest_file;
                     state_nxt = LRX_ST_FREAD;
                  end
                  LRX_LITRET: begin
                     work_nxt = literal;
                     pc_nxt = stack_top_i;
                     pop_nxt = 1'b1;
                     state_nxt = LRX_ST_RET2;
                  end
                  LRX_SUBRET: begin
                     pc_nxt = stack_top_i;
                     pop_nxt = 1'b1;
                     state_nxt = LRX_ST_RET2;
                  end
                  LRX_IRQRET: begin
                     pc_nxt = stack_top_i;
                     pop_nxt = 1'b1;
                     irq_en_nxt = 1'b1;
                     state_nxt = LRX_ST_RET2;
                  end
                  default: begin
                     // Not ours: flag it and leave all state alone
                     illegal_nxt = 1'b1;
                  end
               endcase
            end
         end
         LRX_ST_RET2: begin
            retire_nxt = 1'b1;
            state_nxt = LRX_ST_IDLE;
         end
         LRX_ST_FREAD: begin
            if (dest_file_r) begin
               we_nxt = 1'b1;
               wdata_nxt = xor_res;
            end else begin
               work_nxt = xor_res;
            end
            zero_nxt = is_zero(xor_res);
            pc_nxt = pc_inc(pc_r);
            retire_nxt = 1'b1;
            state_nxt = LRX_ST_IDLE;
         end
         default: begin
            state_nxt = LRX_ST_IDLE;
         end
      endcase
      // Ready is registered, so it tracks the state being entered
      ready_nxt = (state_nxt == LRX_ST_IDLE);
   end

   // State registers; every output is taken from here
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_r <= LRX_ST_IDLE;
         work_r <= `LRX_W_RST;
         zero_r <= `LRX_Z_RST;
         irq_en_r <= `LRX_IRQEN_RST;
         pc_r <= `LRX_PC_RST;
         dest_file_r <= 1'b0;
         faddr_r <= `LRX_FADDR_RST;
         ready_r <= 1'b0;
         retire_r <= 1'b0;
         illegal_r <= 1'b0;
         pop_r <= 1'b0;
         we_r <= 1'b0;
         wdata_r <= `LRX_WDATA_RST;
      end else begin
         state_r <= state_nxt;
         work_r <= work_nxt;
         zero_r <= zero_nxt;
         irq_en_r <= irq_en_nxt;
         pc_r <= pc_nxt;
         dest_file_r <= dest_file_nxt;
         faddr_r <= faddr_nxt;
         ready_r <= ready_nxt;
         retire_r <= retire_nxt;
         illegal_r <= illegal_nxt;
         pop_r <= pop_nxt;
         we_r <= we_nxt;
         wdata_r <= wdata_nxt;
      end
   end

   // Port assignments, all straight from flip-flops
   assign instr_ready_o = ready_r;
   assign retire_o = retire_r;
   assign illegal_o = illegal_r;
   assign stack_pop_o = pop_r;
   assign file_addr_o = faddr_r;
   assign file_we_o = we_r;
   assign file_wdata_o = wdata_r;
   assign global_irq_enable_o = irq_en_r;
   assign work_o = work_r;
   assign zero_flag_o = zero_r;
   assign pc_o = pc_r;

endmodule : lrx_exec
`default_nettype wire

/* verification/lrx_exec_props.sv */
// Port checker for the literal/return/exclusive-OR execution block
`timescale 1ns/1ps
`default_nettype none
`include "lrx_map.svh"
module lrx_exec_props (
   // Clock, reset and issue
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire lrx_pkg::lrx_instr_t instr_i,
   input wire logic instr_ready_o,
   input wire logic retire_o,
   input wire logic illegal_o,
   // Stack and file port
   input wire lrx_pkg::lrx_pc_t stack_top_i,
   input wire logic stack_pop_o,
   input wire lrx_pkg::lrx_faddr_t file_addr_o,
   input wire lrx_pkg::lrx_byte_t file_rdata_i,
   input wire logic file_we_o,
   input wire lrx_pkg::lrx_byte_t file_wdata_o,
   // Interrupt enable and core state
   input wire logic irq_en_clear_i,
   input wire logic global_irq_enable_o,
   input wire lrx_pkg::lrx_byte_t work_o,
   input wire logic zero_flag_o,
   input wire lrx_pkg::lrx_pc_t pc_o
);
   import lrx_pkg::*;
   logic acc;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // A word is taken only while the block is ready
   assign acc = instr_valid_i && instr_ready_o;
   // Second cycle of a two-cycle operation
   sequence done_s;
      retire_o && instr_ready_o;
   endsequence
   sequence pop_s;
      stack_pop_o && !instr_ready_o && pc_o == $past(stack_top_i) && $stable(zero_flag_o);
   endsequence
   ld_lit_a: assert property (
      acc && (instr_i & `LRX_MASK_LIT2) == `LRX_OP_LOADLIT |=>
      retire_o && work_o == $past(instr_i[7:0]) && $stable(zero_flag_o))
      else $error("literal load result wrong");
   sub_ret_a: assert property (
      acc && instr_i == `LRX_OP_SUBRET |=> pop_s ##1 done_s)
      else $error("subroutine return wrong");
   irq_ret_a: assert property (
      acc && instr_i == `LRX_OP_IRQRET |=> pop_s ##0 global_irq_enable_o ##1 done_s)
      else $error("interrupt return wrong");
   lit_ret_a: assert property (
      acc && (instr_i & `LRX_MASK_LIT2) == `LRX_OP_LITRET |=>
      pop_s ##0 work_o == $past(instr_i[7:0]) ##1 done_s)
      else $error("literal return wrong");
   xor_lit_a: assert property (
      acc && (instr_i & `LRX_MASK_LIT3) == `LRX_OP_XORLIT |=>
      work_o == ($past(work_o) ^ $past(instr_i[7:0])) && zero_flag_o == (work_o == 8'h00))
      else $error("literal xor wrong");
   xor_file_a: assert property (
      acc && (instr_i & `LRX_MASK_LIT3) == `LRX_OP_XORFILE && instr_i[`LRX_DEST_BIT] |=>
      file_addr_o == $past(instr_i[6:0]) && !instr_ready_o ##1
      file_we_o && retire_o && file_wdata_o == ($past(work_o, 2) ^ $past(file_rdata_i)) &&
      zero_flag_o == (file_wdata_o == 8'h00) && $stable(work_o))
      else $error("file xor to file wrong");
   xor_work_a: assert property (
      acc && (instr_i & `LRX_MASK_LIT3) == `LRX_OP_XORFILE && !instr_i[`LRX_DEST_BIT] |=>
      !file_we_o ##1 !file_we_o && retire_o &&
      work_o == ($past(work_o, 2) ^ $past(file_rdata_i)) && zero_flag_o == (work_o == 8'h00))
      else $error("file xor to work wrong");
   nop_pc_a: assert property (
      acc && (instr_i & `LRX_MASK_NOP) == `LRX_OP_NOP |=>
      retire_o && pc_o == $past(pc_o) + 13'h0001 && $stable(work_o) && $stable(zero_flag_o))
      else $error("no-op changed state");
   bad_word_a: assert property (
      illegal_o |-> $stable(pc_o) && $stable(work_o) && $stable(zero_flag_o) && !retire_o)
      else $error("unsupported word changed state");
endmodule : lrx_exec_props
`default_nettype wire

/* verification/literal_return_xor_exec_bench.sv */
// Self-checking bench for the literal/return/exclusive-OR execution block
`timescale 1ns/1ps
`default_nettype none
module literal_return_xor_exec_bench;
   import lrx_pkg::*;
   logic mclk_i, rst_i, instr_valid_i, irq_en_clear_i, instr_ready_o, retire_o, illegal_o;
   logic stack_pop_o, file_we_o, global_irq_enable_o, zero_flag_o;
   lrx_instr_t instr_i;
   lrx_pc_t stack_top_i, pc_o;
   lrx_faddr_t file_addr_o;
   lrx_byte_t file_rdata_i, file_wdata_o, work_o;
   int err_count = 0, num_checks = 0, seed = 21, w, z, pc, irq_en;
   lrx_exec lrx_exec_i (.mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(instr_ready_o), .retire_o(retire_o), .illegal_o(illegal_o),
      .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .file_addr_o(file_addr_o),
      .file_rdata_i(file_rdata_i), .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
      .irq_en_clear_i(irq_en_clear_i), .global_irq_enable_o(global_irq_enable_o), .work_o(work_o),
      .zero_flag_o(zero_flag_o), .pc_o(pc_o));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wrap_up;
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   // One operation: model update, issue at a rising edge, compare mid-cycle once settled
   task op(input int k);
      int a, rd, st, r, g;
      lrx_instr_t ins;
      logic busy;
      a = $random(seed) & 255;
      rd = $random(seed) & 255;
      st = $random(seed) & 8191;
      g = $random(seed) & 1;
      // Kind 9 xors W with itself, so the zero flag is forced to set
      if (k == 9) begin
         k = 5;
         a = w;
      end
      case (k)
         0: begin
            ins = {6'h30, a[7:0]};
            w = a;
            pc++;
         end
         1: begin
            ins = 14'h0000;
            pc++;
         end
         2: begin
            ins = {6'h34, a[7:0]};
            w = a;
            pc = st;
         end
         3: begin
            ins = 14'h0008;
            pc = st;
         end
         4: begin
            ins = 14'h0009;
            pc = st;
         end
         5: begin
            ins = {6'h3a, a[7:0]};
            w = w ^ a;
            z = (w == 0);
            pc++;
         end
         6, 7: begin
            ins = {6'h06, k[0], a[6:0]};
            r = w ^ rd;
            z = (r == 0);
            pc++;
         end
         default: begin
            ins = {6'h39, a[7:0]};
         end
      endcase
      if (k == 6) begin
         w = r;
      end
      pc = pc & 8191;
      // Interrupt return wins over a clear in the same cycle
      if (k == 4) begin
         irq_en = 1;
      end else if (g == 1) begin
         irq_en = 0;
      end
      busy = (k > 1 && k < 8 && k != 5);
      @(posedge mclk_i);
      instr_valid_i <= 1'b1;
      instr_i <= ins;
      stack_top_i <= st[12:0];
      file_rdata_i <= rd[7:0];
      irq_en_clear_i <= g[0];
      @(posedge mclk_i);
      // A word offered in the busy cycle must be ignored
      instr_valid_i <= busy;
      instr_i <= 14'h30ff;
      irq_en_clear_i <= 1'b0;
      @(negedge mclk_i);
      chk("ready", instr_ready_o, !busy);
      chk("pop", stack_pop_o, k > 1 && k < 5);
      if (k == 6 || k == 7) chk("faddr", file_addr_o, a & 127);
      if (busy) begin
         @(posedge mclk_i);
         instr_valid_i <= 1'b0;
         @(negedge mclk_i);
      end
      chk("retire", retire_o, k < 8);
      chk("illegal", illegal_o, k == 8);
      chk("we", file_we_o, k == 7);
      if (k == 7) chk("wdata", file_wdata_o, r);
      chk("w", work_o, w);
      chk("z", zero_flag_o, z);
      chk("pc", pc_o, pc);
      chk("irq_en", global_irq_enable_o, irq_en);
   endtask : op
   // Free-running 100 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Reset, every operation kind once, then a random stream
   initial begin
      rst_i = 1'b1;
      instr_valid_i = 1'b0;
      irq_en_clear_i = 1'b0;
      instr_i = 14'h0000;
      stack_top_i = 13'h0000;
      file_rdata_i = 8'h00;
      w = 0;
      z = 0;
      pc = 0;
      irq_en = 0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      // Ready rises at the first edge after release
      @(negedge mclk_i);
      chk("ready", instr_ready_o, 1);
      for (int i = 0; i < 10; i++) op(i);
      repeat (300) op($unsigned($random(seed)) % 10);
      wrap_up;
   end
   // Watchdog well beyond the expected run
   initial begin
      #100000;
      err_count++;
      wrap_up;
   end
endmodule : literal_return_xor_exec_bench
bind lrx_exec lrx_exec_props lrx_exec_props_i (.mclk_i(mclk_i), .rst_i(rst_i),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
   .retire_o(retire_o), .illegal_o(illegal_o), .stack_top_i(stack_top_i),
   .stack_pop_o(stack_pop_o), .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
   .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .irq_en_clear_i(irq_en_clear_i),
   .global_irq_enable_o(global_irq_enable_o), .work_o(work_o), .zero_flag_o(zero_flag_o),
   .pc_o(pc_o));
`default_nettype wire
